// File: nvh_pkg.sv
// package for the nonvolatile sram host controller
// assumes a 50 MHz MCLK; all times are converted to cycle counts here
package nvh_pkg;
  localparam int CLK_MHZ = 50;
  localparam int CLK_NS = 20;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int SEQ_LEN = 6;
  localparam int SEQ_AW = 14;
  // sequence addresses, lower 14 bits only
  localparam logic [13:0] SEQ_A0 = 14'h0e38;
  localparam logic [13:0] SEQ_A1 = 14'h31c7;
  localparam logic [13:0] SEQ_A2 = 14'h03e0;
  localparam logic [13:0] SEQ_A3 = 14'h3c1f;
  localparam logic [13:0] SEQ_A4 = 14'h303f;
  localparam logic [13:0] SEQ_SAVE = 14'h0fc0;
  localparam logic [13:0] SEQ_RESTORE = 14'h0c63;
  // timing figures as printed
  localparam int T_CYCLE_NS = 45;
  localparam int T_WP_NS = 30;
  localparam int T_HSB_PULSE_NS = 15;
  localparam int T_SAVE_MS = 10;
  localparam int T_RESTORE_US = 550;
  localparam int T_RECALL_US = 20;
  localparam int T_RECOVER_NS = 700;
  localparam int T_BUSY_NS = 300;
  // least times round up, longest waits use the maximum figure
  localparam int CYC_ACC = (T_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_WP = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_HSB = (T_HSB_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_BUSY = (T_BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_RECOVER = (T_RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_SAVE = T_SAVE_MS * 1000 * CLK_MHZ;
  localparam int CYC_RESTORE = T_RESTORE_US * CLK_MHZ;
  localparam int CYC_RECALL = T_RECALL_US * CLK_MHZ;
  localparam int CNT_W = 20;

  typedef enum logic [1:0] {NVH_OP_READ, NVH_OP_WRITE, NVH_OP_SAVE, NVH_OP_RESTORE} nvh_op_t;

  typedef struct packed {
    nvh_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic hw_save;
  } nvh_cmd_t;

  typedef struct packed {
    logic e_n;
    logic g_n;
    logic w_n;
    logic [ADDR_W-1:0] addr;
  } nvh_bus_t;
endpackage : nvh_pkg

// File: nvh_host.sv
// host controller that drives an asynchronous nonvolatile sram by its pins
// assumes one MCLK domain; the device's busy line arrives asynchronously
`timescale 1ns/1ps
`default_nettype none
module nvh_host (
  input wire logic MCLK,
  input wire logic SRST,
  input wire nvh_pkg::nvh_cmd_t CMD,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  output logic [nvh_pkg::DATA_W-1:0] RDATA,
  output logic RDATA_VALID,
  output logic BUSY,
  output nvh_pkg::nvh_bus_t BUS,
  output logic [nvh_pkg::DATA_W-1:0] DQ_O,
  input wire logic [nvh_pkg::DATA_W-1:0] DQ_I,
  output logic DQ_OE_N,
  input wire logic SAVE_BUSY_N_I,
  output logic SAVE_BUSY_N_O,
  output logic SAVE_BUSY_N_OE_N
);
  typedef enum logic [3:0] {
    NVH_S_POWERUP, NVH_S_IDLE, NVH_S_RD, NVH_S_WR, NVH_S_WR_END,
    NVH_S_SEQ_LOW, NVH_S_SEQ_HIGH, NVH_S_NV_WAIT, NVH_S_HSB_DRIVE,
    NVH_S_HSB_BUSY, NVH_S_RECOVER
  } nvh_state_t;

  nvh_state_t state;
  logic [nvh_pkg::CNT_W-1:0] cnt;
  logic [2:0] step;
  nvh_pkg::nvh_cmd_t cur;
  logic [2:0] hsb_sync;
  logic hsb_low;
  logic [nvh_pkg::CNT_W-1:0] next_cnt;

  function automatic logic [nvh_pkg::SEQ_AW-1:0] seq_addr(input logic [2:0] s,
                                                         input logic restore);
    unique case (s)
      3'h0: seq_addr = nvh_pkg::SEQ_A0;
      3'h1: seq_addr = nvh_pkg::SEQ_A1;
      3'h2: seq_addr = nvh_pkg::SEQ_A2;
      3'h3: seq_addr = nvh_pkg::SEQ_A3;
      3'h4: seq_addr = nvh_pkg::SEQ_A4;
      default: seq_addr = restore ? nvh_pkg::SEQ_RESTORE : nvh_pkg::SEQ_SAVE;
    endcase
  endfunction : seq_addr

  function automatic logic [nvh_pkg::CNT_W-1:0] cyc(input int n);
    int m;
    m = n - 1;
    cyc = m[nvh_pkg::CNT_W-1:0];
  endfunction : cyc

  // busy line synchroniser; a low counts once stages two and three agree
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      hsb_sync <= 3'h7;
      hsb_low <= 1'b0;
    end else begin
      hsb_sync <= {hsb_sync[1:0], SAVE_BUSY_N_I};
      if (hsb_sync[1] == hsb_sync[2]) begin
        hsb_low <= ~hsb_sync[2];
      end
    end
  end

  assign next_cnt = (cnt == '0) ? '0 : cnt - 1'b1;

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      state <= NVH_S_POWERUP;
      cnt <= cyc(nvh_pkg::CYC_RESTORE);
      step <= 3'h0;
      cur <= '0;
      CMD_READY <= 1'b0;
      RDATA <= '0;
      RDATA_VALID <= 1'b0;
      BUSY <= 1'b1;
      BUS <= '{e_n: 1'b1, g_n: 1'b1, w_n: 1'b1, addr: '0};
      DQ_O <= '0;
      DQ_OE_N <= 1'b1;
      SAVE_BUSY_N_O <= 1'b1;
      SAVE_BUSY_N_OE_N <= 1'b1;
    end else begin
      RDATA_VALID <= 1'b0;
      cnt <= next_cnt;
      unique case (state)
        NVH_S_POWERUP: begin
          // controls stay deselected, write enable high, while restore runs
          if (cnt == '0) begin
            state <= NVH_S_IDLE;
            CMD_READY <= 1'b1;
            BUSY <= 1'b0;
          end
        end
        NVH_S_IDLE: begin
          if (hsb_low) begin
            state <= NVH_S_HSB_BUSY;
            CMD_READY <= 1'b0;
            BUSY <= 1'b1;
          end else if (CMD_VALID) begin
            cur <= CMD;
            CMD_READY <= 1'b0;
            BUSY <= 1'b1;
            BUS.addr <= CMD.addr;
            cnt <= cyc(nvh_pkg::CYC_ACC);
            step <= 3'h0;
            if (CMD.hw_save) begin
              state <= NVH_S_HSB_DRIVE;
              SAVE_BUSY_N_O <= 1'b0;
              SAVE_BUSY_N_OE_N <= 1'b0;
              cnt <= cyc(nvh_pkg::CYC_HSB);
            end else begin
              unique case (CMD.op)
                nvh_pkg::NVH_OP_READ: begin
                  state <= NVH_S_RD;
                  BUS.e_n <= 1'b0;
                  BUS.g_n <= 1'b0;
                end
                nvh_pkg::NVH_OP_WRITE: begin
                  state <= NVH_S_WR;
                  BUS.e_n <= 1'b0;
                  BUS.w_n <= 1'b0;
                  DQ_O <= CMD.wdata;
                  DQ_OE_N <= 1'b0;
                  cnt <= cyc(nvh_pkg::CYC_WP);
                end
                nvh_pkg::NVH_OP_SAVE, nvh_pkg::NVH_OP_RESTORE: begin
                  state <= NVH_S_SEQ_LOW;
                  BUS.addr <= {1'b0, seq_addr(3'h0, 1'b0)};
                  BUS.e_n <= 1'b0;
                end
              endcase
            end
          end
        end
        NVH_S_RD: begin
          // address and controls held until the sample point
          if (cnt == '0) begin
            RDATA <= DQ_I;
            RDATA_VALID <= 1'b1;
            BUS.e_n <= 1'b1;
            BUS.g_n <= 1'b1;
            state <= NVH_S_IDLE;
            CMD_READY <= 1'b1;
            BUSY <= 1'b0;
          end
        end
        NVH_S_WR: begin
          if (cnt == '0) begin
            BUS.w_n <= 1'b1;
            BUS.e_n <= 1'b1;
            state <= NVH_S_WR_END;
          end
        end
        NVH_S_WR_END: begin
          // data and address held one cycle past the rising edge
          DQ_OE_N <= 1'b1;
          state <= NVH_S_IDLE;
          CMD_READY <= 1'b1;
          BUSY <= 1'b0;
        end
        NVH_S_SEQ_LOW: begin
          if (cnt == '0) begin
            BUS.e_n <= 1'b1;
            cnt <= cyc(nvh_pkg::CYC_ACC);
            state <= NVH_S_SEQ_HIGH;
          end
        end
        NVH_S_SEQ_HIGH: begin
          if (cnt == '0) begin
            if (step == 3'(nvh_pkg::SEQ_LEN - 1)) begin
              state <= NVH_S_NV_WAIT;
              cnt <= (cur.op == nvh_pkg::NVH_OP_RESTORE) ? cyc(nvh_pkg::CYC_RECALL)
                                                         : cyc(nvh_pkg::CYC_SAVE);
            end else begin
              // next step follows directly, nothing else interleaved
              step <= step + 3'h1;
              BUS.addr <= {1'b0, seq_addr(step + 3'h1,
                           cur.op == nvh_pkg::NVH_OP_RESTORE)};
              BUS.e_n <= 1'b0;
              cnt <= cyc(nvh_pkg::CYC_ACC);
              state <= NVH_S_SEQ_LOW;
            end
          end
        end
        NVH_S_NV_WAIT: begin
          if (cnt == '0) begin
            state <= NVH_S_IDLE;
            CMD_READY <= 1'b1;
            BUSY <= 1'b0;
          end
        end
        NVH_S_HSB_DRIVE: begin
          if (cnt == '0) begin
            SAVE_BUSY_N_OE_N <= 1'b1;
            SAVE_BUSY_N_O <= 1'b1;
            cnt <= cyc(nvh_pkg::CYC_BUSY);
            state <= NVH_S_HSB_BUSY;
          end
        end
        NVH_S_HSB_BUSY: begin
          // wait the busy window, then for the line to be seen high
          if (cnt == '0 && !hsb_low) begin
            cnt <= cyc(nvh_pkg::CYC_RECOVER);
            state <= NVH_S_RECOVER;
          end
        end
        NVH_S_RECOVER: begin
          if (hsb_low) begin
            state <= NVH_S_HSB_BUSY;
          end else if (cnt == '0) begin
            state <= NVH_S_IDLE;
            CMD_READY <= 1'b1;
            BUSY <= 1'b0;
          end
        end
      endcase
    end
  end

  sequence s_step_low;
    !BUS.e_n && BUS.w_n;
  endsequence

  chk_seq_write_high: assert property (@(posedge MCLK) disable iff (SRST)
    (state == NVH_S_SEQ_LOW) |-> s_step_low)
    else $error("write enable low during sequence step");
  chk_write_oe_high: assert property (@(posedge MCLK) disable iff (SRST)
    !BUS.w_n |-> BUS.g_n && !DQ_OE_N)
    else $error("output enable low during write");
  chk_read_ctrl: assert property (@(posedge MCLK) disable iff (SRST)
    !BUS.g_n |-> !BUS.e_n && BUS.w_n)
    else $error("read controls wrong");
  chk_addr_hold: assert property (@(posedge MCLK) disable iff (SRST)
    (!BUS.w_n && $past(!BUS.w_n)) |-> $stable(BUS.addr))
    else $error("address moved during write");
  chk_powerup_nowrite: assert property (@(posedge MCLK) disable iff (SRST)
    (state == NVH_S_POWERUP) |-> BUS.w_n && BUS.e_n)
    else $error("write state during restore");
  chk_hsb_pulse: assert property (@(posedge MCLK) disable iff (SRST)
    $fell(SAVE_BUSY_N_OE_N) |-> !SAVE_BUSY_N_O && state == NVH_S_HSB_DRIVE ##1
      state == NVH_S_HSB_BUSY)
    else $error("save request pulse not driven low for a full cycle");
  chk_seq_top_bit: assert property (@(posedge MCLK) disable iff (SRST)
    (state == NVH_S_SEQ_LOW) |-> !BUS.addr[nvh_pkg::ADDR_W-1])
    else $error("sequence top address bit set");
  chk_step_pulse: assert property (@(posedge MCLK) disable iff (SRST)
    $rose(BUS.e_n) && $past(state) == NVH_S_SEQ_LOW |-> BUS.e_n [*2])
    else $error("chip select high time too short");
endmodule : nvh_host
`default_nettype wire

// File: nvh_dev_model.sv
// behavioural model of the nonvolatile sram, seen from its pins
// assumes the bench resolves the open-drain busy line with a pull-up
`timescale 1ns/1ps
`default_nettype none
module nvh_dev_model #(
  parameter int SAVE_NS = 2000,
  parameter int RECALL_NS = 5000
) (
  input wire nvh_pkg::nvh_bus_t bus,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  input wire logic busy_line,
  input wire logic storage_low,
  output logic dev_drive,
  output int n_save,
  output int n_restore,
  output int n_err
);
  logic [7:0] mem [32768];
  logic [7:0] nv [32768];
  logic [7:0] shown;
  logic [14:0] wa;
  logic inhibit = 1;
  logic written = 0;
  logic in_wr = 0;
  int step = 0;
  logic [13:0] seq [6] = '{14'h0e38, 14'h31c7, 14'h03e0, 14'h3c1f, 14'h303f, 14'h0fc0};
  event go_save;
  event go_rec;
  wire rd = !bus.e_n && !bus.g_n && bus.w_n && busy_line && !inhibit;
  initial begin
    for (int i = 0; i < 32768; i++) nv[i] = 8'(i) ^ 8'h5a;
    dev_drive = 0;
    n_save = 0;
    n_restore = 0;
    n_err = 0;
    #100;
    mem = nv;
    inhibit = 0;
  end
  always @* if (rd) shown = mem[bus.addr];
  // released bus shows the inverse of the last byte
  assign dq_out = rd ? shown : ~shown;
  always @(negedge (bus.e_n | bus.w_n)) begin
    in_wr = 1;
    wa = bus.addr;
    if (!bus.g_n) n_err++;
  end
  always @(posedge (bus.e_n | bus.w_n)) if (in_wr) begin
    in_wr = 0;
    if (wa !== bus.addr) n_err++;
    if (busy_line && !inhibit) begin
      mem[bus.addr] = dq_in;
      written = 1;
    end
    step = 0;
  end
  always @(posedge bus.e_n) if (bus.w_n === 1'b1 && busy_line && !inhibit) begin
    if (bus.addr[13:0] == seq[step]) step++;
    else if (step == 5 && bus.addr[13:0] == 14'h0c63) step = 7;
    else step = (bus.addr[13:0] == 14'h0e38) ? 1 : 0;
    if (step == 6) ->go_save;
    if (step == 7) ->go_rec;
  end
  always @(go_save) begin
    n_save++;
    inhibit = 1;
    dev_drive = 1;
    #(SAVE_NS);
    nv = '{default: 8'hff};
    nv = mem;
    written = 0;
    dev_drive = 0;
    step = 0;
    wait (busy_line);
    #500;
    inhibit = 0;
  end
  always @(go_rec) begin
    n_restore++;
    inhibit = 1;
    #(RECALL_NS);
    mem = nv;
    written = 0;
    step = 0;
    inhibit = 0;
  end
  always @(negedge busy_line) if (!dev_drive) begin
    #200;
    if (written) begin
      dev_drive = 1;
      #800;
      ->go_save;
    end else begin
      inhibit = 1;
      wait (busy_line);
      inhibit = 0;
    end
  end
  always @(posedge storage_low) begin
    dev_drive = 1;
    #1000;
    if (written) ->go_save;
    else dev_drive = 0;
  end
endmodule : nvh_dev_model
`default_nettype wire

// File: nvh_host_tb.sv
// self-checking bench for the nonvolatile sram host controller
// assumes the package and the device model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module nvh_host_tb;
  logic mclk = 0;
  logic srst = 1;
  nvh_pkg::nvh_cmd_t cmd_s = '0;
  logic cmd_valid = 0;
  logic storage_low = 0;
  logic cmd_ready, rdata_valid, busy, dq_oe_n, sb_o, sb_oe_n, dev_drive;
  logic [7:0] rdata, dq_o, dq_i;
  nvh_pkg::nvh_bus_t bus;
  int n_save, n_restore, n_err, i;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  wire hardware_save_busy_n = (!sb_oe_n || dev_drive) ? 1'b0 : 1'b1;
  nvh_host u_nvh_host (.MCLK(mclk), .SRST(srst), .CMD(cmd_s), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .RDATA(rdata), .RDATA_VALID(rdata_valid), .BUSY(busy), .BUS(bus),
    .DQ_O(dq_o), .DQ_I(dq_i), .DQ_OE_N(dq_oe_n), .SAVE_BUSY_N_I(hardware_save_busy_n),
    .SAVE_BUSY_N_O(sb_o), .SAVE_BUSY_N_OE_N(sb_oe_n));
  nvh_dev_model u_nvh_dev_model (.bus(bus), .dq_in(dq_o), .dq_out(dq_i),
    .busy_line(hardware_save_busy_n), .storage_low(storage_low), .dev_drive(dev_drive),
    .n_save(n_save), .n_restore(n_restore), .n_err(n_err));
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic conclude;
    if (n_fail == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic wait_ready(input int lim);
    for (i = 0; i < lim && cmd_ready !== 1'b1; i++) @(negedge mclk);
    `CHK("ready", 1'b1, cmd_ready)
  endtask : wait_ready
  task automatic cmd(input nvh_pkg::nvh_op_t op, input logic [14:0] a, input logic [7:0] d,
                     input logic hw);
    wait_ready(1100);
    cmd_s = '{op: op, addr: a, wdata: d, hw_save: hw};
    cmd_valid = 1;
    @(negedge mclk);
    cmd_valid = 0;
  endtask : cmd
  task automatic rd_chk(input logic [14:0] a, input logic [7:0] ex);
    cmd(nvh_pkg::NVH_OP_READ, a, 8'h00, 1'b0);
    for (i = 0; i < 8 && rdata_valid !== 1'b1; i++) @(negedge mclk);
    `CHK("read valid", 1'b1, rdata_valid)
    `CHK("read data", ex, rdata)
  endtask : rd_chk
  task automatic t_power_up;
    `CHK("ready in power-up wait", 1'b0, cmd_ready)
    `CHK("write strobe idle", 1'b1, bus.w_n)
    wait_ready(28000);
    rd_chk(15'h4321, 8'h7b);
  endtask : t_power_up
  task automatic t_write_read;
    cmd(nvh_pkg::NVH_OP_WRITE, 15'h7fff, 8'ha5, 1'b0);
    `CHK("write data driven", 1'b0, dq_oe_n)
    cmd(nvh_pkg::NVH_OP_WRITE, 15'h3fff, 8'h3c, 1'b0);
    rd_chk(15'h7fff, 8'ha5);
    rd_chk(15'h3fff, 8'h3c);
    `CHK("bus misuse", 0, n_err)
  endtask : t_write_read
  task automatic t_hw_save;
    cmd(nvh_pkg::NVH_OP_READ, 15'h0000, 8'h00, 1'b1);
    `CHK("save request drive", 2'b00, {sb_o, sb_oe_n})
    repeat (14) @(negedge mclk);
    `CHK("ready during save", 1'b0, cmd_ready)
    `CHK("busy line", 1'b0, hardware_save_busy_n)
    wait_ready(400);
    `CHK("saves", 1, n_save)
    rd_chk(15'h7fff, 8'ha5);
  endtask : t_hw_save
  task automatic t_restore;
    cmd(nvh_pkg::NVH_OP_WRITE, 15'h0010, 8'hee, 1'b0);
    cmd(nvh_pkg::NVH_OP_RESTORE, 15'h0000, 8'h00, 1'b0);
    wait_ready(1100);
    `CHK("restores", 1, n_restore)
    rd_chk(15'h0010, 8'h4a);
    rd_chk(15'h7fff, 8'ha5);
  endtask : t_restore
  task automatic t_power_loss;
    storage_low = 1;
    repeat (10) @(negedge mclk);
    `CHK("ready while line low", 1'b0, cmd_ready)
    storage_low = 0;
    wait_ready(200);
    `CHK("saves", 1, n_save)
    rd_chk(15'h3fff, 8'h3c);
  endtask : t_power_loss
  task automatic t_sw_save;
    cmd(nvh_pkg::NVH_OP_SAVE, 15'h0000, 8'h00, 1'b0);
    for (i = 0; i < 60 && n_save != 2; i++) @(negedge mclk);
    `CHK("saves", 2, n_save)
    `CHK("busy", 1'b1, busy)
    `CHK("bus misuse", 0, n_err)
  endtask : t_sw_save
  initial begin
    repeat (4) @(negedge mclk);
    srst = 0;
    @(negedge mclk);
    t_power_up();
    t_write_read();
    t_hw_save();
    t_restore();
    t_power_loss();
    t_sw_save();
    conclude();
  end
endmodule : nvh_host_tb
`default_nettype wire
